/* logic_cluster_cfg.svh */
// offsets, field positions, reset values and sizes of the logic cluster
`ifndef LOGIC_CLUSTER_CFG_SVH
`define LOGIC_CLUSTER_CFG_SVH

`define CELL_COUNT        10
`define ROW_CLOCK_W       6
`define LOCAL_CTRL_W      6
`define BUS_ADDR_W        6

`define OFF_CELL_BASE     6'h00
`define OFF_SRC_A         6'h28
`define OFF_SRC_B         6'h2c
`define OFF_STATUS        6'h30

`define F_MASK_LSB        0
`define F_FF_LSB          16
`define F_CLK_SEL         18
`define F_OUT_A           19
`define F_OUT_B           20
`define F_OUT_LOCAL       21
`define F_FEEDBACK        22
`define F_LUT_CHAIN       23
`define F_REG_CHAIN       24
`define F_ARITH           25
`define F_ACLR_LSB        26
`define F_ALOAD_EN        28
`define F_SYNC_EN         29

`define F_SRC_CLK0        0
`define F_SRC_CLK1        4
`define F_SRC_ENA0        8
`define F_SRC_ENA1        12
`define F_SRC_ACLR0       16
`define F_SRC_ACLR1       20
`define F_SRC_SCLR        0
`define F_SRC_ALOAD       4
`define F_SRC_SLOAD       8
`define F_SRC_ADDSUB      12
`define F_EDGE0_FALL      16
`define F_EDGE1_FALL      17

`define CELL_CFG_MASK     32'h3fffffff
`define SRC_A_MASK        32'h00ffffff
`define SRC_B_MASK        32'h0003ffff
`define RST_CELL_CFG      32'h00000000
`define RST_SRC_A         32'h00ffffff
`define RST_SRC_B         32'h0000ffff

`endif

/* logic_cluster_pkg.sv */
// types shared by the logic cluster
`default_nettype none
package logic_cluster_pkg;
    typedef enum logic [1:0] {ff_d, ff_t, ff_jk, ff_sr} ff_type_e;
    typedef logic [3:0] src_sel_t;
    typedef logic [1:0] aclr_sel_t;
endpackage : logic_cluster_pkg
`default_nettype wire

/* logic_cluster.sv */
// logic cluster of ten cells with shared control and an Avalon-MM configuration slave
`include "logic_cluster_cfg.svh"
`default_nettype none

// Behaviour
// - ten cells share one control set
// - ten cluster controls: clocks, enables, clears, loads, addsub
// - each cluster clock gated by its own enable
// - rising and falling edges need both clocks
// - enable low stops clock, registers hold
// - asynchronous load with high data presets register
// - addsub select makes cell adder or subtractor
// - controls picked from six row clocks, local lines
// - four-input lookup realises any function
// - register works as D, T, JK, SR
// - register has data, aload data, clock, enable, clear, aload
// - aload data comes from fourth lookup input
// - combinational use bypasses register to outputs
// - three outputs, each lookup or register driven
// - lookup and register drive different outputs
// - register output feeds own lookup input
// - registered and unregistered lookup shown together
// - lookup chain and register chain to neighbour
// - subtract inverts B, carry-in one at first cell
// - synchronous clear and load act on all registers; here only cells with [29] set obey them
module logic_cluster
    import logic_cluster_pkg::*;
(
    input  wire logic                              clk,
    input  wire logic                              srst,
    input  wire logic [`BUS_ADDR_W-1:0]            avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output var  logic [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    input  wire logic [`ROW_CLOCK_W-1:0]           row_clock,
    input  wire logic [`LOCAL_CTRL_W-1:0]          local_ctrl,
    input  wire logic [4*`CELL_COUNT-1:0]          cell_inputs,
    input  wire logic                              cluster_carry_in,
    input  wire logic                              lut_chain_in,
    input  wire logic                              reg_chain_in,
    output logic [`CELL_COUNT-1:0]                 route_out_a,
    output logic [`CELL_COUNT-1:0]                 route_out_b,
    output logic [`CELL_COUNT-1:0]                 local_out,
    output logic [`CELL_COUNT-1:0]                 lut_chain_out,
    output logic [`CELL_COUNT-1:0]                 reg_chain_out,
    output logic                                   cluster_carry_out
);
    import logic_cluster_pkg::*;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // cell i at byte offset 4*i, i = 0 to 9
    //   [15:0]  lookup mask, indexed {in3, in2, in1, in0}
    //   [17:16] register kind: D, T, JK, SR
    //   [18]    second cluster clock when set
    //   [19]    route a shows the register
    //   [20]    route b shows the register
    //   [21]    local output shows the register
    //   [22]    register feeds its own in3
    //   [23]    in0 from the previous cell's lookup
    //   [24]    data from the previous cell's register
    //   [25]    arithmetic: result is the sum bit
    //   [27:26] clear select: none, first, second
    //   [28]    asynchronous load enable
    //   [29]    synchronous clear and load enable
    // source a, four-bit selects
    //   [3:0] clock 0    [7:4] clock 1
    //   [11:8] enable 0  [15:12] enable 1
    //   [19:16] clear 0  [23:20] clear 1
    // source b
    //   [3:0] sync clear  [7:4] async load
    //   [11:8] sync load  [15:12] add/subtract
    //   [16] clock 0 falling  [17] clock 1 falling
    // status: [9:0] registers, [10] carry out
    // reserved bits read zero; unmapped writes are dropped

    // each access waits exactly one cycle: the first edge
    // loads read data and drops waitrequest, the second edge
    // completes it; a write lands on that second edge only

    // limitations
    // clear and load settle at the next system edge, so they
    // are not truly asynchronous to the cluster clocks
    // cluster clocks are sampled lines: a level must last one
    // system cycle for its edge to be seen
    // JK and SR take their second control from in2
    // load data comes from the in3 pin even with feedback on
    // cells outside arithmetic still pass the carry on
    // wide adders chain carries between clusters outside
    // keep the low two address bits zero

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // codes 0-5 pick a row clock, 6-11 a local line, 12-15 mean unused
    function automatic logic pick_source(input src_sel_t sel,
                                         input logic [`ROW_CLOCK_W-1:0] rows,
                                         input logic [`LOCAL_CTRL_W-1:0] locs);
        logic hit;

        hit = 1'b0;
        if (sel < 4'h6)
            hit = rows[sel[2:0]];
        else if (sel < 4'hc)
            hit = locs[3'(sel - 4'h6)];
        return hit;
    endfunction : pick_source

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  be,
                                                input logic [31:0] keep);
        logic [31:0] res;

        res = old_val;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[8*b +: 8] = new_val[8*b +: 8];
        return res & keep;
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // configuration storage and bus slave
    // ------------------------------------------------------------
    logic [31:0]              cell_cfg_reg [`CELL_COUNT];
    logic [31:0]              src_a_reg;
    logic [31:0]              src_b_reg;
    logic                     done_reg;
    logic                     bus_req;
    logic                     bus_commit;

    logic [`CELL_COUNT-1:0]   q_vec;
    logic [`CELL_COUNT:0]     carry;

    // waitrequest is combinational so the first edge of a
    // request always sees it high; read data then stands
    // until the next read, so a late master still sees it

    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~done_reg;
    assign bus_commit      = bus_req & done_reg & avs_write;

    // one wait cycle on every access, then release for one edge
    always_ff @(posedge clk)
    begin
        if (srst)
            done_reg <= 1'b0;
        else
            done_reg <= bus_req & ~done_reg;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            src_a_reg <= `RST_SRC_A;
            src_b_reg <= `RST_SRC_B;
        end
        else if (bus_commit)
        begin
            if (avs_address == `OFF_SRC_A)
                src_a_reg <= merge_bytes(src_a_reg, avs_writedata, avs_byteenable, `SRC_A_MASK);
            if (avs_address == `OFF_SRC_B)
                src_b_reg <= merge_bytes(src_b_reg, avs_writedata, avs_byteenable, `SRC_B_MASK);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            avs_readdata <= 32'h00000000;
        else if (bus_req & ~done_reg & avs_read)
        begin
            avs_readdata <= 32'h00000000;
            if (avs_address < 6'(`OFF_CELL_BASE + 4 * `CELL_COUNT) && avs_address[1:0] == 2'h0)
                avs_readdata <= cell_cfg_reg[avs_address[5:2]];
            else if (avs_address == `OFF_SRC_A)
                avs_readdata <= src_a_reg;
            else if (avs_address == `OFF_SRC_B)
                avs_readdata <= src_b_reg;
            else if (avs_address == `OFF_STATUS)
                avs_readdata <= {21'h000000, cluster_carry_out, q_vec};
        end
    end

    // ------------------------------------------------------------
    // cluster-wide control signals
    // ------------------------------------------------------------
    logic       ctl_clk [2];
    logic       ctl_ena [2];
    logic       ctl_aclr [2];

    logic       ctl_sclr;
    logic       ctl_aload;
    logic       ctl_sload;
    logic       ctl_addsub;

    logic [1:0] clk_prev_reg;
    logic [1:0] tick;

    // unused controls sit at code 15 and so read low;
    // a low enable stops its tick outright, which is how
    // the cluster clock is switched off
    always_comb
    begin
        ctl_clk[0]  = pick_source(src_a_reg[`F_SRC_CLK0 +: 4], row_clock, local_ctrl);
        ctl_clk[1]  = pick_source(src_a_reg[`F_SRC_CLK1 +: 4], row_clock, local_ctrl);

        ctl_ena[0]  = pick_source(src_a_reg[`F_SRC_ENA0 +: 4], row_clock, local_ctrl);
        ctl_ena[1]  = pick_source(src_a_reg[`F_SRC_ENA1 +: 4], row_clock, local_ctrl);

        ctl_aclr[0] = pick_source(src_a_reg[`F_SRC_ACLR0 +: 4], row_clock, local_ctrl);
        ctl_aclr[1] = pick_source(src_a_reg[`F_SRC_ACLR1 +: 4], row_clock, local_ctrl);

        ctl_sclr    = pick_source(src_b_reg[`F_SRC_SCLR +: 4], row_clock, local_ctrl);
        ctl_aload   = pick_source(src_b_reg[`F_SRC_ALOAD +: 4], row_clock, local_ctrl);
        ctl_sload   = pick_source(src_b_reg[`F_SRC_SLOAD +: 4], row_clock, local_ctrl);
        ctl_addsub  = pick_source(src_b_reg[`F_SRC_ADDSUB +: 4], row_clock, local_ctrl);
    end

    // cluster clocks are sampled lines, so their edges become one-cycle ticks
    // reset value matches the idle select, so no false edge follows reset
    always_ff @(posedge clk)
    begin
        if (srst)
            clk_prev_reg <= 2'b00;
        else
            clk_prev_reg <= {ctl_clk[1], ctl_clk[0]};
    end

    // each clock has its own edge choice, so mixed edges take both clocks
    assign tick[0] = ctl_ena[0] & (src_b_reg[`F_EDGE0_FALL] ? (clk_prev_reg[0] & ~ctl_clk[0])
                                                            : (~clk_prev_reg[0] & ctl_clk[0]));
    assign tick[1] = ctl_ena[1] & (src_b_reg[`F_EDGE1_FALL] ? (clk_prev_reg[1] & ~ctl_clk[1])
                                                            : (~clk_prev_reg[1] & ctl_clk[1]));

    // subtract: every cell flips B and cell 0 gets carry one,
    // giving A plus not B plus one

    assign carry[0]          = ctl_addsub ? 1'b1 : cluster_carry_in;
    assign cluster_carry_out = carry[`CELL_COUNT];

    // ------------------------------------------------------------
    // logic cells
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CELL_COUNT; gi++)
        begin : g_cell
            logic [31:0] cfg;
            logic [3:0]  raw;

            logic        in0;
            logic        in3;
            logic        lut_val;
            logic        b_op;
            logic        sum;
            logic        lut_res;

            logic        d_src;
            logic        tick_sel;
            logic        aclr_hit;
            logic        aload_hit;

            logic        sync_on;
            logic        q_reg;
            logic        ff_next;

            aclr_sel_t   aclr_sel;
            ff_type_e    ff_kind;

            always_ff @(posedge clk)
            begin
                if (srst)
                    cell_cfg_reg[gi] <= `RST_CELL_CFG;
                else if (bus_commit && avs_address == 6'(`OFF_CELL_BASE + 4 * gi))
                    cell_cfg_reg[gi] <= merge_bytes(cell_cfg_reg[gi], avs_writedata, avs_byteenable,
                                                    `CELL_CFG_MASK);
            end

            assign cfg      = cell_cfg_reg[gi];
            assign raw      = cell_inputs[4*gi +: 4];
            assign aclr_sel = cfg[`F_ACLR_LSB +: 2];
            assign ff_kind  = ff_type_e'(cfg[`F_FF_LSB +: 2]);
            assign sync_on  = cfg[`F_SYNC_EN];

            if (gi == 0)
            begin : g_first
                assign in0   = cfg[`F_LUT_CHAIN] ? lut_chain_in : raw[0];
                assign d_src = cfg[`F_REG_CHAIN] ? reg_chain_in : lut_res;
            end
            else
            begin : g_next
                assign in0   = cfg[`F_LUT_CHAIN] ? lut_chain_out[gi-1] : raw[0];
                assign d_src = cfg[`F_REG_CHAIN] ? q_vec[gi-1] : lut_res;
            end

            assign in3     = cfg[`F_FEEDBACK] ? q_reg : raw[3];
            assign lut_val = cfg[`F_MASK_LSB + {in3, raw[2], raw[1], in0}];

            // one-bit add; subtract flips B, the carry-in one comes from cell 0
            assign b_op        = raw[1] ^ ctl_addsub;
            assign sum         = in0 ^ b_op ^ carry[gi];
            assign carry[gi+1] = (in0 & b_op) | (in0 & carry[gi]) | (b_op & carry[gi]);
            assign lut_res     = cfg[`F_ARITH] ? sum : lut_val;

            assign tick_sel  = cfg[`F_CLK_SEL] ? tick[1] : tick[0];
            assign aclr_hit  = (aclr_sel == 2'h1 && ctl_aclr[0]) || (aclr_sel == 2'h2 && ctl_aclr[1]);
            assign aload_hit = cfg[`F_ALOAD_EN] & ctl_aload;

            // second control of JK and SR is the third lookup input
            always_comb
            begin
                case (ff_kind)
                    ff_d:    ff_next = d_src;
                    ff_t:    ff_next = q_reg ^ d_src;
                    ff_jk:   ff_next = (d_src & ~q_reg) | (~raw[2] & q_reg);
                    ff_sr:   ff_next = d_src | (~raw[2] & q_reg);
                    default: ff_next = q_reg;
                endcase
            end

            // asynchronous clear and load act at the next system edge, not on a cluster tick
            always_ff @(posedge clk)
            begin
                if (srst)
                    q_reg <= 1'b0;
                else if (aclr_hit)
                    q_reg <= 1'b0;
                else if (aload_hit)
                    q_reg <= raw[3];
                else if (tick_sel)
                begin
                    if (sync_on && ctl_sclr)
                        q_reg <= 1'b0;
                    else if (sync_on && ctl_sload)
                        q_reg <= raw[3];
                    else
                        q_reg <= ff_next;
                end
            end

            assign q_vec[gi]         = q_reg;
            assign lut_chain_out[gi] = lut_res;
            assign reg_chain_out[gi] = q_reg;
            // lookup path is direct so combinational use sees no register
            assign route_out_a[gi]   = cfg[`F_OUT_A] ? q_reg : lut_res;
            assign route_out_b[gi]   = cfg[`F_OUT_B] ? q_reg : lut_res;
            assign local_out[gi]     = cfg[`F_OUT_LOCAL] ? q_reg : lut_res;
        end
    endgenerate

endmodule : logic_cluster
`default_nettype wire

/* logic_cluster_chk.sv */
// assertions on bus timing and read-back of the logic cluster
`include "logic_cluster_cfg.svh"
`default_nettype none
module logic_cluster_chk
(
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic [`BUS_ADDR_W-1:0] avs_address,
    input wire logic                   avs_read,
    input wire logic                   avs_write,
    input wire logic [31:0]            avs_readdata,
    input wire logic                   avs_waitrequest,
    input wire logic [`CELL_COUNT-1:0] reg_chain_out,
    input wire logic                   cluster_carry_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire logic req = avs_read || avs_write;
    wire logic rd_ok = avs_read && !avs_waitrequest;
    wire logic st_rd = rd_ok && avs_address == `OFF_STATUS;
    // --------------------------------
    // properties
    // --------------------------------
    property p_first_wait; $rose(req) |-> avs_waitrequest; endproperty
    property p_one_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_idle; !req |-> !avs_waitrequest; endproperty
    property p_status; st_rd |-> avs_readdata[9:0] == $past(reg_chain_out); endproperty
    property p_carry; st_rd |-> avs_readdata[10] == $past(cluster_carry_out); endproperty
    property p_unmapped; rd_ok && avs_address > `OFF_STATUS |-> avs_readdata == 32'h0; endproperty
    property p_reset; $fell(srst) |-> reg_chain_out == '0; endproperty
    // read data must stand between captures, the master may sample late
    property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
    a_first_wait: assert property (p_first_wait) else $error("request answered without wait");
    a_one_wait: assert property (p_one_wait) else $error("wait lasted over one cycle");
    a_idle: assert property (p_idle) else $error("wait raised while idle");
    a_status: assert property (p_status) else $error("status bits differ from registers");
    a_carry: assert property (p_carry) else $error("status carry differs");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_reset: assert property (p_reset) else $error("registers not cleared by reset");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    c_status: cover property (st_rd);
    c_write: cover property (avs_write && !avs_waitrequest);
    c_reset: cover property ($fell(srst));
endmodule : logic_cluster_chk
bind logic_cluster logic_cluster_chk u_logic_cluster_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reg_chain_out(reg_chain_out), .cluster_carry_out(cluster_carry_out));
`default_nettype wire

/* logic_cluster_bench.sv */
// self-checking bench of the logic cluster against a cell model
`include "logic_cluster_cfg.svh"
`default_nettype none
module logic_cluster_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import logic_cluster_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0]  avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  row_clock = '0;
    logic [5:0]  local_ctrl = '0;
    logic [39:0] cell_inputs = '0;
    logic        cluster_carry_in = 1'b0;
    logic        lut_chain_in = 1'b0;
    logic        reg_chain_in = 1'b0;
    logic [9:0]  route_out_a;
    logic [9:0]  route_out_b;
    logic [9:0]  local_out;
    logic [9:0]  lut_chain_out;
    logic [9:0]  reg_chain_out;
    logic        cluster_carry_out;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [31:0] cfg [10];
    logic [31:0] src_b;
    logic [31:0] rd;
    logic [9:0]  q = '0;
    logic [5:0]  prev_rc = '0;
    logic_cluster u_logic_cluster (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .row_clock(row_clock),
        .local_ctrl(local_ctrl), .cell_inputs(cell_inputs), .cluster_carry_in(cluster_carry_in),
        .lut_chain_in(lut_chain_in), .reg_chain_in(reg_chain_in), .route_out_a(route_out_a),
        .route_out_b(route_out_b), .local_out(local_out), .lut_chain_out(lut_chain_out),
        .reg_chain_out(reg_chain_out), .cluster_carry_out(cluster_carry_out));
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            conclude();
        end
    end
    // ---------------------------
    // shared tasks and cell model
    // ---------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        logic w;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        w = 1'b1;
        while (w !== 1'b0)
        begin
            @(posedge clk);
            w = avs_waitrequest;
            rd = avs_readdata;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    function automatic logic [9:0] luts(input logic [9:0] qv);
        logic [3:0] idx;
        for (int i = 0; i < 10; i++)
        begin
            idx = cell_inputs[4*i +: 4];
            if (cfg[i][22]) idx[3] = qv[i];
            if (cfg[i][23]) idx[0] = (i == 0) ? lut_chain_in : luts[i-1];
            luts[i] = cfg[i][idx];
        end
    endfunction : luts
    function automatic logic [9:0] pick(input int b, input logic [9:0] lt);
        for (int i = 0; i < 10; i++)
            pick[i] = cfg[i][b] ? q[i] : lt[i];
    endfunction : pick
    task automatic step(input logic [5:0] rc, input logic [5:0] lc, input logic [39:0] ci);
        logic [9:0] lt;
        logic [9:0] d;
        logic [9:0] nq;
        logic [1:0] tick;
        @(posedge clk);
        row_clock <= rc;
        local_ctrl <= lc;
        cell_inputs <= ci;
        cluster_carry_in <= 1'($urandom);
        lut_chain_in <= 1'($urandom);
        reg_chain_in <= 1'($urandom);
        #1;
        lt = luts(q);
        for (int k = 0; k < 2; k++)
            tick[k] = lc[k] & (src_b[16+k] ? prev_rc[k] & !rc[k] : !prev_rc[k] & rc[k]);
        prev_rc = rc;
        for (int i = 0; i < 10; i++)
        begin
            d[i] = cfg[i][24] ? ((i == 0) ? reg_chain_in : q[i-1]) : lt[i];
            case (ff_type_e'(cfg[i][17:16]))
                ff_d: nq[i] = d[i];
                ff_t: nq[i] = q[i] ^ d[i];
                ff_jk: nq[i] = (d[i] & !q[i]) | (!ci[4*i+2] & q[i]);
                default: nq[i] = d[i] | (!ci[4*i+2] & q[i]);
            endcase
            if (cfg[i][29] && lc[3]) nq[i] = ci[4*i+3];
            if (cfg[i][29] && lc[2]) nq[i] = 1'b0;
            if (!tick[cfg[i][18]]) nq[i] = q[i];
            if (cfg[i][28] && rc[5]) nq[i] = ci[4*i+3];
            if ((cfg[i][27:26] == 2'd1 && lc[4]) || (cfg[i][27:26] == 2'd2 && lc[5])) nq[i] = 1'b0;
        end
        @(posedge clk);
        q = nq;
        #1;
    endtask : step
    // ---------------------------
    // main sequence
    // ---------------------------
    initial
    begin
        logic [9:0]  a;
        logic [9:0]  bx;
        logic [10:0] sum;
        logic [39:0] ci;
        void'($urandom(30809));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 14; i++)
        begin
            bus(1'b0, 6'(4*i), 32'h0, 4'hf);
            check("reset value", rd, (i == 10) ? `RST_SRC_A : (i == 11) ? `RST_SRC_B : 32'h0);
        end
        bus(1'b1, 6'h34, 32'hffffffff, 4'hf);
        bus(1'b0, 6'h34, 32'h0, 4'hf);
        check("unmapped", rd, 32'h0);
        bus(1'b1, 6'h0c, 32'hffffffff, 4'h2);
        bus(1'b0, 6'h0c, 32'h0, 4'hf);
        check("lane write", rd, 32'h0000ff00);
        bus(1'b1, `OFF_SRC_B, 32'hffffffff, 4'hf);
        bus(1'b0, `OFF_SRC_B, 32'h0, 4'hf);
        check("reserved bits", rd, `SRC_B_MASK);
        $display("test bus done");
        src_b = 32'h00004fff;
        bus(1'b1, `OFF_SRC_B, src_b, 4'hf);
        for (int i = 0; i < 10; i++)
        begin
            cfg[i] = 32'h02000000;
            bus(1'b1, 6'(4*i), cfg[i], 4'hf);
        end
        repeat (24)
        begin
            a = 10'($urandom);
            bx = 10'($urandom);
            for (int i = 0; i < 10; i++)
                ci[4*i +: 4] = {2'($urandom), bx[i], a[i]};
            step({1'b0, prev_rc[4] ^ 1'($urandom), 4'h0}, 6'h0, ci);
            if (prev_rc[4]) bx = ~bx;
            sum = a + bx + (prev_rc[4] | cluster_carry_in);
            check("sum", 32'(lut_chain_out), 32'(sum[9:0]));
            check("carry", 32'(cluster_carry_out), 32'(sum[10]));
        end
        bus(1'b0, `OFF_STATUS, 32'h0, 4'hf);
        check("status", rd, {21'h0, sum[10], q});
        $display("test arithmetic done");
        for (int p = 0; p < 4; p++)
        begin
            src_b = 32'h00004958 | (32'(p) << 16);
            bus(1'b1, `OFF_SRC_A, 32'h00ba7610, 4'hf);
            bus(1'b1, `OFF_SRC_B, src_b, 4'hf);
            for (int i = 0; i < 10; i++)
            begin
                cfg[i] = ($urandom & 32'h31ffffff) | (32'($urandom % 3) << 26);
                if (cfg[i][17:16] != 2'd0) cfg[i][24] = 1'b0;
                bus(1'b1, 6'(4*i), cfg[i], 4'hf);
            end
            repeat (40)
            begin
                step(6'($urandom) & {1'($urandom), 5'h1f}, 6'($urandom) & {2'($urandom), 4'hf}, 40'({$urandom, $urandom}));
                check("registers", 32'(reg_chain_out), 32'(q));
                check("lookups", 32'(lut_chain_out), 32'(luts(q)));
                check("route a", 32'(route_out_a), 32'(pick(19, luts(q))));
                check("route b", 32'(route_out_b), 32'(pick(20, luts(q))));
                check("local out", 32'(local_out), 32'(pick(21, luts(q))));
            end
            step(prev_rc & 6'h03, 6'h0, cell_inputs);
            bus(1'b0, `OFF_STATUS, 32'h0, 4'hf);
            check("status regs", 32'(rd[9:0]), 32'(q));
            $display("test random pass %0d done", p);
        end
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check("registers after reset", 32'(reg_chain_out), 32'h0);
        bus(1'b0, `OFF_SRC_A, 32'h0, 4'hf);
        check("source after reset", rd, `RST_SRC_A);
        $display("test second reset done");
        conclude();
    end
endmodule : logic_cluster_bench
`default_nettype wire
